// ==== rsc_defs.svh ====
// constants for the reset-cause register block
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
`define RSC_REG_ADDR     8'hef
`define RSC_REG_PAGE     8'h00
`define RSC_BIT_FLASH    6
`define RSC_BIT_CMP      5
`define RSC_BIT_SW       4
`define RSC_BIT_WDT      3
`define RSC_BIT_CLKLOSS  2
`define RSC_BIT_POR      1
`define RSC_BIT_PIN      0
`define RSC_FLAGS_POR    7'h02
`define RSC_CLK_NS       50
`define RSC_HOLD_NS      400
`define RSC_HOLD_CYC     ((`RSC_HOLD_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`endif

// ==== rsc_pkg.sv ====
// types for the reset-cause register block
package rsc_pkg;
  typedef struct packed {
    logic flash_err;
    logic cmp;
    logic sw;
    logic wdt;
    logic clk_loss;
    logic por;
    logic pin;
  } rsc_cause_t;

  typedef enum logic [1:0] {
    RSC_RUN  = 2'b01,
    RSC_HOLD = 2'b10
  } rsc_state_t;
endpackage

// ==== rsc_reset_source_flags.sv ====
// reset-cause register, source enables and system reset request
//
// Contract
// - cause register at 0xef, page 0x00
// - bit 6 flags flash error reset
// - bit 5 enables comparator reset, flags it
// - writing bit 4 forces reset, then flags
// - bit 3 flags watchdog overflow reset
// - bit 2 enables clock-loss detector, flags it
// - writing 0 disables clock-loss detector resets
// - writing bit 1 selects supply monitor reset
// - bit 1 set after power-on/monitor reset
// - with power-on flag, other flags undefined
// - bit 0 flags external pin reset
// - comparator reset while plus below minus
`timescale 1ns/100ps
`include "rsc_defs.svh"

module rsc_reset_source_flags (
  input  wire logic       MCLK,        // system clock, 20 MHz
  input  wire logic       RST_N,       // power-on reset, async low
  input  wire logic [7:0] SFR_ADDR,    // register address
  input  wire logic [7:0] SFR_PAGE,    // register page
  input  wire logic       SFR_WE,      // write strobe
  input  wire logic       SFR_RE,      // read strobe
  input  wire logic [7:0] SFR_WDATA,   // write data
  output logic      [7:0] SFR_RDATA,   // read data, one cycle later
  input  wire logic       PIN_RST_N,   // external reset pin
  input  wire logic       CMP_OUT,     // comparator output, low = trip
  input  wire logic       VMON_OK,     // supply above threshold
  input  wire logic       CLK_LOSS,    // clock-loss detector timeout
  input  wire logic       WDT_OVF,     // watchdog overflow pulse
  input  wire logic       FLASH_ERR,   // flash access error pulse
  output logic            SYS_RST,     // system reset request
  output logic            CMP_RST_EN,  // comparator reset enabled
  output logic            CLK_LOSS_EN, // clock-loss detector enabled
  output logic            VMON_RST_EN  // supply monitor reset enabled
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] sync_nxt;
  logic       pin_s;
  logic       cmp_s;
  logic       vmon_s;
  logic       loss_s;

  always_comb
  begin
    sync_nxt = {CLK_LOSS, VMON_OK, CMP_OUT, PIN_RST_N};
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sync1_r <= 4'h7;
      sync2_r <= 4'h7;
    end
    else
    begin
      sync1_r <= sync_nxt;
      sync2_r <= sync1_r;
    end
  end

  assign pin_s  = sync2_r[0];
  assign cmp_s  = sync2_r[1];
  assign vmon_s = sync2_r[2];
  assign loss_s = sync2_r[3];

  // ****************************************************************
  // cause capture and reset hold
  // ****************************************************************
  rsc_pkg::rsc_state_t state_r;
  rsc_pkg::rsc_state_t state_nxt;
  rsc_pkg::rsc_cause_t flags_r;
  rsc_pkg::rsc_cause_t flags_nxt;
  rsc_pkg::rsc_cause_t cause;
  logic [3:0]          cnt_r;
  logic [3:0]          cnt_nxt;
  logic                cmp_en_r;
  logic                cmp_en_nxt;
  logic                loss_en_r;
  logic                loss_en_nxt;
  logic                vmon_en_r;
  logic                vmon_en_nxt;
  logic                sys_rst_nxt;
  logic                sel;
  logic                wr_hit;
  logic                rd_hit;
  logic [7:0]          rdata_nxt;

  assign sel    = (SFR_ADDR == `RSC_REG_ADDR)
               && (SFR_PAGE == `RSC_REG_PAGE);
  assign wr_hit = sel && SFR_WE && (state_r == rsc_pkg::RSC_RUN);
  assign rd_hit = sel && SFR_RE;

  always_comb
  begin
    cause           = '0;
    cause.pin       = !pin_s;
    cause.cmp       = cmp_en_r && !cmp_s;
    cause.sw        = wr_hit && SFR_WDATA[`RSC_BIT_SW];
    cause.wdt       = WDT_OVF;
    cause.clk_loss  = loss_en_r && loss_s;
    cause.por       = vmon_en_r && !vmon_s;
    cause.flash_err = FLASH_ERR;
  end

  always_comb
  begin
    state_nxt    = state_r;
    flags_nxt    = flags_r;
    cnt_nxt      = cnt_r;
    cmp_en_nxt   = cmp_en_r;
    loss_en_nxt  = loss_en_r;
    vmon_en_nxt  = vmon_en_r;
    sys_rst_nxt  = 1'b0;
    unique case (state_r)
      rsc_pkg::RSC_RUN:
      begin
        // flag bits 7, 6, 3 and 0 are never taken from a write
        if (wr_hit)
        begin
          cmp_en_nxt  = SFR_WDATA[`RSC_BIT_CMP];
          loss_en_nxt = SFR_WDATA[`RSC_BIT_CLKLOSS];
          vmon_en_nxt = SFR_WDATA[`RSC_BIT_POR];
        end
        if (cause != '0)
        begin
          // all simultaneous causes are kept; with por set the rest
          // carry no promise to software
          flags_nxt   = cause;
          state_nxt   = rsc_pkg::RSC_HOLD;
          cnt_nxt     = 4'(`RSC_HOLD_CYC - 1);
          cmp_en_nxt  = 1'b0;
          loss_en_nxt = 1'b0;
          vmon_en_nxt = 1'b0;
          sys_rst_nxt = 1'b1;
        end
      end
      rsc_pkg::RSC_HOLD:
      begin
        sys_rst_nxt = 1'b1;
        if (cnt_r != 4'h0)
        begin
          cnt_nxt = cnt_r - 4'h1;
        end
        else if (pin_s)
        begin
          // pin held low stretches the reset
          state_nxt   = rsc_pkg::RSC_RUN;
          sys_rst_nxt = 1'b0;
        end
      end
    endcase
    rdata_nxt = rd_hit ? {1'b0, flags_r} : 8'h00;
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_r     <= rsc_pkg::RSC_RUN;
      flags_r     <= `RSC_FLAGS_POR;
      cnt_r       <= 4'h0;
      cmp_en_r    <= 1'b0;
      loss_en_r   <= 1'b0;
      vmon_en_r   <= 1'b0;
      SYS_RST     <= 1'b0;
      SFR_RDATA   <= 8'h00;
    end
    else
    begin
      state_r     <= state_nxt;
      flags_r     <= flags_nxt;
      cnt_r       <= cnt_nxt;
      cmp_en_r    <= cmp_en_nxt;
      loss_en_r   <= loss_en_nxt;
      vmon_en_r   <= vmon_en_nxt;
      SYS_RST     <= sys_rst_nxt;
      SFR_RDATA   <= rdata_nxt;
    end
  end

  assign CMP_RST_EN  = cmp_en_r;
  assign CLK_LOSS_EN = loss_en_r;
  assign VMON_RST_EN = vmon_en_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic run;
  assign run = (state_r == rsc_pkg::RSC_RUN);

  chk_read_top_zero: assert property (
    @(posedge MCLK) disable iff (!RST_N) SFR_RDATA[7] == 1'b0)
    else $error("bit 7 read back nonzero");

  chk_read_value: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    rd_hit |=> SFR_RDATA == {1'b0, $past(flags_r)})
    else $error("read data does not match cause flags");

  chk_sw_force: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    wr_hit && SFR_WDATA[4] |=> SYS_RST && flags_r.sw ##1 SYS_RST)
    else $error("software force did not reset and flag");

  chk_wdt_flag: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    run && WDT_OVF |=> flags_r.wdt && SYS_RST)
    else $error("watchdog overflow not recorded");

  chk_flash_flag: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    run && FLASH_ERR |=> flags_r.flash_err && SYS_RST)
    else $error("flash error not recorded");

  chk_cmp_trip: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    run && CMP_RST_EN && !cmp_s |=> SYS_RST && flags_r.cmp)
    else $error("comparator trip missed");

  chk_loss_gated: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    $rose(flags_r.clk_loss) |-> $past(CLK_LOSS_EN))
    else $error("clock-loss reset while detector disabled");

  chk_por_flag: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    run && VMON_RST_EN && !vmon_s |=> flags_r.por && SYS_RST)
    else $error("supply monitor reset not flagged");

  chk_pin_flag: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    run && !pin_s |=> flags_r.pin && SYS_RST)
    else $error("pin reset not flagged");

  chk_enable_write: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    wr_hit && (cause == '0) |=> CMP_RST_EN == $past(SFR_WDATA[5])
      && CLK_LOSS_EN == $past(SFR_WDATA[2])
      && VMON_RST_EN == $past(SFR_WDATA[1]))
    else $error("enable bits not taken from write");

  chk_hold_len: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    $rose(SYS_RST) |-> SYS_RST [*8])
    else $error("reset request shorter than hold time");

endmodule

// ==== test_rsc_reset_source_flags.sv ====
// self-checking bench for the reset-cause register block
`timescale 1ns/100ps
`include "rsc_defs.svh"

module test_rsc_reset_source_flags;
  logic       MCLK, RST_N, SFR_WE, SFR_RE, PIN_RST_N, CMP_OUT, VMON_OK;
  logic       CLK_LOSS, WDT_OVF, FLASH_ERR, SYS_RST, CMP_RST_EN;
  logic       CLK_LOSS_EN, VMON_RST_EN;
  logic [7:0] SFR_ADDR, SFR_PAGE, SFR_WDATA, SFR_RDATA, q, en, a, d, ens;
  integer     miscompares, n_checks, seed, i, k, n;

  rsc_reset_source_flags rsc_reset_source_flags_inst (
    .MCLK(MCLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR), .SFR_PAGE(SFR_PAGE),
    .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .SFR_WDATA(SFR_WDATA),
    .SFR_RDATA(SFR_RDATA), .PIN_RST_N(PIN_RST_N), .CMP_OUT(CMP_OUT),
    .VMON_OK(VMON_OK), .CLK_LOSS(CLK_LOSS), .WDT_OVF(WDT_OVF),
    .FLASH_ERR(FLASH_ERR), .SYS_RST(SYS_RST), .CMP_RST_EN(CMP_RST_EN),
    .CLK_LOSS_EN(CLK_LOSS_EN), .VMON_RST_EN(VMON_RST_EN));

  // enables placed at their register bit positions
  assign ens = {2'h0, CMP_RST_EN, 2'h0, CLK_LOSS_EN, VMON_RST_EN, 1'h0};

  initial
  begin
    MCLK = 0;
    forever #25 MCLK = ~MCLK;
  end

  // ********************************************
  // helpers
  // ********************************************
  function automatic logic [7:0] exp_of(input integer c);
    integer b;
    case (c)
      0: b = `RSC_BIT_WDT;
      1: b = `RSC_BIT_FLASH;
      2: b = `RSC_BIT_PIN;
      3: b = `RSC_BIT_CMP;
      4: b = `RSC_BIT_CLKLOSS;
      5: b = `RSC_BIT_POR;
      default: b = `RSC_BIT_SW;
    endcase
    return 8'h01 << b;
  endfunction

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // causes back to their quiet levels
  task automatic idle;
    PIN_RST_N = 1;
    CMP_OUT = 1;
    VMON_OK = 1;
    CLK_LOSS = 0;
    WDT_OVF = 0;
    FLASH_ERR = 0;
  endtask

  // one bus cycle; read data lands in q
  task automatic acc(input logic       we,
                     input logic [7:0] ad,
                     input logic [7:0] dt);
    @(negedge MCLK);
    SFR_ADDR = ad;
    SFR_WDATA = dt;
    SFR_WE = we;
    SFR_RE = !we;
    @(negedge MCLK);
    SFR_WE = 0;
    SFR_RE = 0;
    q = SFR_RDATA;
  endtask

  // cause released once the reset is seen, so it cannot retrigger
  task automatic rst_wait;
    k = 0;
    n = 0;
    while (SYS_RST !== 1'b1 && k < 10)
    begin
      @(negedge MCLK);
      k++;
    end
    idle();
    while (SYS_RST === 1'b1 && n < 40)
    begin
      @(negedge MCLK);
      n++;
    end
    if (n == 0 || n == 40)
    begin
      miscompares++;
      end_of_test();
    end
  endtask

  initial
  begin
    miscompares = 0;
    n_checks = 0;
    seed = 32'h5320cb4e;
    RST_N = 0;
    SFR_ADDR = 8'h00;
    SFR_PAGE = 8'h00;
    SFR_WE = 0;
    SFR_RE = 0;
    SFR_WDATA = 8'h00;
    idle();
    repeat (20) @(negedge MCLK);
    RST_N = 1;
    acc(0, 8'hef, 8'h00);
    chk(q, exp_of(5));
    for (i = 0; i < 7; i++)
    begin
      en = (i == 3) ? 8'h20 : (i == 4) ? 8'h04 : (i == 5) ? 8'h02 : 8'h00;
      if (en != 8'h00)
        acc(1, 8'hef, en);
      chk(ens, en);
      case (i)
        0: WDT_OVF = 1;
        1: FLASH_ERR = 1;
        2: PIN_RST_N = 0;
        3: CMP_OUT = 0;
        4: CLK_LOSS = 1;
        5: VMON_OK = 0;
        default: acc(1, 8'hef, 8'h10);
      endcase
      rst_wait();
      if (i != 2)
        chk(n[7:0], 8'(`RSC_HOLD_CYC));
      chk(ens, 8'h00);
      acc(0, 8'hef, 8'h00);
      chk(q, exp_of(i));
      $display("cause test %0d done", i);
    end
    acc(1, 8'hef, 8'h04);
    acc(1, 8'hef, 8'h00);
    CLK_LOSS = 1;
    repeat (6)
    begin
      @(negedge MCLK);
      chk({7'h00, SYS_RST}, 8'h00);
    end
    idle();
    $display("detector disable test done");
    for (i = 0; i < 16; i++)
    begin
      d = 8'($random(seed));
      a = 8'($random(seed));
      if (a == 8'hef)
        a = 8'h00;
      SFR_PAGE = i[0] ? 8'h01 : 8'h00;
      acc(1, i[0] ? 8'hef : a, 8'h36);
      acc(0, i[0] ? 8'hef : a, 8'h00);
      chk(q, 8'h00);
      SFR_PAGE = 8'h00;
      acc(1, 8'hef, d & 8'hc9);
      chk({7'h00, SYS_RST}, 8'h00);
      acc(0, 8'hef, 8'h00);
      chk(q, 8'h10);
    end
    $display("decode test done");
    // mid-run power-on reset must bring back the por flag alone
    @(negedge MCLK);
    RST_N = 0;
    repeat (3) @(negedge MCLK);
    RST_N = 1;
    acc(0, 8'hef, 8'h00);
    chk(q, 8'h02);
    chk(ens, 8'h00);
    $display("second power-on test done");
    end_of_test();
  end
endmodule
